// [hdl/diff_out.sv]
// Registered true/complement pair for a differential status output
`timescale 1ns/1ps
`default_nettype none
module diff_out (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic level,
   output var  logic outP,
   output var  logic outN
);
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         outP <= 1'b0;
         outN <= 1'b1;
      end
      else
      begin
         outP <= level;
         outN <= ~level;
      end
   end
endmodule
`default_nettype wire

// [hdl/shutter_interlock_supervisor.sv]
// Shutter, interlock and latched fault supervisor
//
// What this block does
// RL1 - Closed status only when present and closed
// RL2 - Closed status off during latching faults
// RL3 - Open status only when present and open
// RL4 - Open status off during system faults
// RL5 - Command high opens, low closes shutter
// RL6 - Fault on transit exceeding travel time
// RL7 - Fault if closed commanded but not sensed
// RL8 - Shutter fault latches and shuts system down
// RL9 - Over-temperature when any sensor out of range
// RL10 - Over-temperature latches as system shutdown fault
// RL11 - Laser runs only with system loop closed
// RL12 - System loop overrides all other interlocks
// RL13 - Shutter moves only with shutter loop closed
// RL14 - Shutter loop never blocks laser operation
// RL15 - Host leaves shutter loop open without shutter
// RL16 - Run-permit flag derived from system loop
// RL17 - Status outputs active-high differential pairs
// RL18 - Open system loop kills modulation and simmer
// RL19 - Travel time is a cycle-count parameter
// RL20 - Latched faults hold until device reset
`timescale 1ns/1ps
`default_nettype none
module shutter_interlock_supervisor
   import shutter_pkg::*;
#(
   // Travel allowance
   // RL19 - configurable travel time
   parameter int TRAVEL_LIMIT = TRAVEL_CYCLES,
   parameter int CLOSE_LIMIT  = CLOSE_CHECK_CYCLES,
   parameter int NTEMP        = TEMP_SOURCES
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             shutterCmd,
   input  wire logic             sysLoopClosed,
   input  wire logic             shutterLoopClosed,
   input  wire logic             senseOpen,
   input  wire logic             senseClosed,
   input  wire logic [NTEMP-1:0] tempOutOfRange,
   output var  logic             driveOpen,
   output var  logic             driveClose,
   output var  logic             runPermit,
   output var  logic             modEnable,
   output var  logic             simmerEnable,
   output var  logic             closedStatP,
   output var  logic             closedStatN,
   output var  logic             openStatP,
   output var  logic             openStatN,
   output var  logic             shutterFaultP,
   output var  logic             shutterFaultN,
   output var  logic             overTempP,
   output var  logic             overTempN
);
   localparam int CW = $clog2(TRAVEL_LIMIT > CLOSE_LIMIT ? TRAVEL_LIMIT + 1 : CLOSE_LIMIT + 1);
   localparam int SW = NTEMP + 5;

   logic [SW-1:0]    syncIn;
   logic [SW-1:0]    syncOut;
   logic             cmdS;
   logic             sysLoopS;
   logic             shLoopS;
   logic             openS;
   logic             closedS;
   logic [NTEMP-1:0] tempS;

   assign syncIn = {tempOutOfRange, senseClosed, senseOpen, shutterLoopClosed, sysLoopClosed,
                    shutterCmd};

   // Every pin passes two flops before use
   sync_bits #(
      .WIDTH (SW)
   ) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  (syncIn),
      .dout (syncOut)
   );

   assign cmdS     = syncOut[0];
   assign sysLoopS = syncOut[1];
   assign shLoopS  = syncOut[2];
   assign openS    = syncOut[3];
   assign closedS  = syncOut[4];
   assign tempS    = syncOut[SW-1:5];

   shutter_state_t state;
   shutter_state_t next_state;
   logic [CW-1:0]  travelCnt;
   logic [CW-1:0]  closeCnt;
   logic           shutterFault;
   logic           overTemp;

   // RL15 - open shutter loop means no shutter
   wire present = shLoopS;
   wire anyFault = shutterFault | overTemp;

   // RL12 - system loop overrides everything
   // RL16 - run permit from system loop
   // RL14 - shutter loop absent from permit
   wire permit = sysLoopS & ~anyFault;

   // RL13 - actuation needs shutter loop
   wire shutterEnabled = present & permit;

   // RL5 - command high opens
   wire wantOpen = shutterEnabled & cmdS;

   wire travelTimeout = (travelCnt >= CW'(TRAVEL_LIMIT));
   wire moving = (state == ST_OPENING) || (state == ST_CLOSING);

   // RL6 - transit timeout
   wire transitFault = present & moving & travelTimeout;

   // RL7 - close commanded but not closed after settle time
   wire closeFault = present & ~cmdS & ~closedS & (closeCnt >= CW'(CLOSE_LIMIT));

   // RL9 - any sensor out of range
   wire tempFault = |tempS;

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_CLOSED:
            if (wantOpen)
               next_state = ST_OPENING;
         ST_OPENING:
            if (!wantOpen)
               next_state = ST_CLOSING;
            else if (openS && !closedS)
               next_state = ST_OPEN;
         ST_OPEN:
            if (!wantOpen)
               next_state = ST_CLOSING;
         ST_CLOSING:
            if (wantOpen)
               next_state = ST_OPENING;
            else if (closedS && !openS)
               next_state = ST_CLOSED;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state <= ST_CLOSED;
      else
         state <= next_state;
   end

   // Restart travel timing on every new transit
   wire newTransit = (next_state != state) &&
                     ((next_state == ST_OPENING) || (next_state == ST_CLOSING));

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         travelCnt <= '0;
      else if (newTransit || !moving)
         travelCnt <= '0;
      else if (!travelTimeout)
         travelCnt <= travelCnt + CW'(1);
   end

   // Closed check counts while close is commanded and position is not closed
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         closeCnt <= '0;
      else if (!present || cmdS || closedS)
         closeCnt <= '0;
      else if (closeCnt < CW'(CLOSE_LIMIT))
         closeCnt <= closeCnt + CW'(1);
   end

   // RL8 - latch shutter fault
   // RL20 - cleared only by reset
   // RL10 - latch over-temperature
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         shutterFault <= FAULT_RESET;
         overTemp     <= FAULT_RESET;
      end
      else
      begin
         if (transitFault || closeFault)
            shutterFault <= 1'b1;
         if (tempFault)
            overTemp <= 1'b1;
      end
   end

   // A disabled shutter with its shutter loop closed is driven closed so a fault leaves the beam blocked
   wire next_driveOpen = (next_state == ST_OPENING) || (next_state == ST_OPEN);

   // RL11 - laser runs only with loop closed
   // RL18 - loop open kills modulation and simmer
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         driveOpen    <= 1'b0;
         driveClose   <= 1'b0;
         runPermit    <= 1'b0;
         modEnable    <= 1'b0;
         simmerEnable <= 1'b0;
      end
      else
      begin
         driveOpen    <= next_driveOpen;
         driveClose   <= present & ~next_driveOpen;
         runPermit    <= permit;
         modEnable    <= permit;
         simmerEnable <= permit;
      end
   end

   // RL1 - closed status when present and closed
   // RL2 - suppressed during latching faults
   wire closedLevel = present & closedS & ~openS & ~anyFault;
   // RL3 - open status when present and open
   // RL4 - suppressed during system faults
   wire openLevel = present & openS & ~closedS & ~anyFault;

   // RL17 - differential active-high outputs
   diff_out u_closed (
      .clk   (clk),
      .rstn  (rstn),
      .level (closedLevel),
      .outP  (closedStatP),
      .outN  (closedStatN)
   );

   diff_out u_open (
      .clk   (clk),
      .rstn  (rstn),
      .level (openLevel),
      .outP  (openStatP),
      .outN  (openStatN)
   );

   diff_out u_sfault (
      .clk   (clk),
      .rstn  (rstn),
      .level (shutterFault),
      .outP  (shutterFaultP),
      .outN  (shutterFaultN)
   );

   diff_out u_otemp (
      .clk   (clk),
      .rstn  (rstn),
      .level (overTemp),
      .outP  (overTempP),
      .outN  (overTempN)
   );
endmodule
`default_nettype wire

// [hdl/shutter_pkg.sv]
// Shared constants for the shutter and interlock supervisor
package shutter_pkg;
   // System clock rate in kHz
   localparam int CLK_KHZ            = 25000;
   // Default shutter travel allowance in milliseconds
   localparam int TRAVEL_MS          = 100;
   localparam int TRAVEL_CYCLES      = TRAVEL_MS * CLK_KHZ;
   // Default settle allowance after a close command before checking position
   localparam int CLOSE_CHECK_MS     = 200;
   localparam int CLOSE_CHECK_CYCLES = CLOSE_CHECK_MS * CLK_KHZ;
   // Reset value of the latched faults
   localparam logic FAULT_RESET      = 1'b0;
   // Width of the peripheral temperature report vector
   localparam int TEMP_SOURCES       = 4;

   typedef enum logic [1:0] {
      ST_CLOSED,
      ST_OPENING,
      ST_OPEN,
      ST_CLOSING
   } shutter_state_t;
endpackage

// [hdl/sync_bits.sv]
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stage <= '0;
         dout  <= '0;
      end
      else
      begin
         stage <= din;
         dout  <= stage;
      end
   end
endmodule
`default_nettype wire

// [tb/shutter_interlock_supervisor_assertions.sv]
// Port-level checks for the shutter and interlock supervisor
`timescale 1ns/1ps
`default_nettype none
module shutter_interlock_supervisor_assertions #(
   parameter int NTEMP = 4
) (
   input wire logic             clk,
   input wire logic             rstn,
   input wire logic             sysLoopClosed,
   input wire logic             shutterLoopClosed,
   input wire logic             senseOpen,
   input wire logic             senseClosed,
   input wire logic [NTEMP-1:0] tempOutOfRange,
   input wire logic             driveOpen,
   input wire logic             runPermit,
   input wire logic             modEnable,
   input wire logic             simmerEnable,
   input wire logic             closedStatP,
   input wire logic             closedStatN,
   input wire logic             openStatP,
   input wire logic             openStatN,
   input wire logic             shutterFaultP,
   input wire logic             shutterFaultN,
   input wire logic             overTempP,
   input wire logic             overTempN
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_closed_sense: assert property (!senseClosed[*5] |-> !closedStatP)
      else $error("closed status without sensor");
   a_closed_fault: assert property (closedStatP |-> !shutterFaultP && !overTempP)
      else $error("closed status during fault");
   a_open_sense: assert property (!senseOpen[*5] |-> !openStatP)
      else $error("open status without sensor");
   a_open_fault: assert property (openStatP |-> !shutterFaultP && !overTempP)
      else $error("open status during fault");
   a_fault_latch: assert property (shutterFaultP |=> shutterFaultP)
      else $error("shutter fault dropped");
   a_temp_raise: assert property ((|tempOutOfRange)[*6] |-> overTempP)
      else $error("over-temperature not raised");
   a_fault_stop: assert property ((shutterFaultP || overTempP)[*3] |-> !runPermit)
      else $error("run permitted during fault");
   a_loop_stop: assert property (!sysLoopClosed[*5] |-> !(runPermit || modEnable || simmerEnable))
      else $error("laser enabled with system loop open");
   a_shutter_gate: assert property (!shutterLoopClosed[*5] |-> !driveOpen)
      else $error("shutter driven with shutter loop open");
   a_diff_pairs: assert property ((closedStatN ^ closedStatP) && (openStatN ^ openStatP) && (shutterFaultN ^ shutterFaultP) && (overTempN ^ overTempP))
      else $error("differential pair not complementary");
endmodule
bind shutter_interlock_supervisor shutter_interlock_supervisor_assertions #(.NTEMP(NTEMP)) u_chk (
   .clk(clk), .rstn(rstn), .sysLoopClosed(sysLoopClosed), .shutterLoopClosed(shutterLoopClosed),
   .senseOpen(senseOpen), .senseClosed(senseClosed), .tempOutOfRange(tempOutOfRange),
   .driveOpen(driveOpen), .runPermit(runPermit), .modEnable(modEnable),
   .simmerEnable(simmerEnable), .closedStatP(closedStatP), .closedStatN(closedStatN),
   .openStatP(openStatP), .openStatN(openStatN), .shutterFaultP(shutterFaultP),
   .shutterFaultN(shutterFaultN), .overTempP(overTempP), .overTempN(overTempN));
`default_nettype wire

// [tb/shutter_interlock_supervisor_tb.sv]
// Directed testbench for the shutter and interlock supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module shutter_interlock_supervisor_tb;
   logic       clk, rstn, shutterCmd, sysLoopClosed, shutterLoopClosed, stuck, bump;
   logic [3:0] temp;
   logic       senseOpen, senseClosed, driveOpen, driveClose, runPermit, modEnable;
   logic       simmerEnable, closedStatP, closedStatN, openStatP, openStatN;
   logic       shutterFaultP, shutterFaultN, overTempP, overTempN;
   int         bad_count = 0;
   int         n_compared = 0;
   initial
   begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   shutter_interlock_supervisor #(.TRAVEL_LIMIT(20), .CLOSE_LIMIT(40)) u_dut (
      .clk(clk), .rstn(rstn), .shutterCmd(shutterCmd), .sysLoopClosed(sysLoopClosed),
      .shutterLoopClosed(shutterLoopClosed), .senseOpen(senseOpen), .senseClosed(senseClosed),
      .tempOutOfRange(temp), .driveOpen(driveOpen), .driveClose(driveClose),
      .runPermit(runPermit), .modEnable(modEnable), .simmerEnable(simmerEnable),
      .closedStatP(closedStatP), .closedStatN(closedStatN), .openStatP(openStatP),
      .openStatN(openStatN), .shutterFaultP(shutterFaultP), .shutterFaultN(shutterFaultN),
      .overTempP(overTempP), .overTempN(overTempN));
   shutter_mech_model u_mech (.clk(clk), .rstn(rstn), .driveOpen(driveOpen),
      .driveClose(driveClose), .stuck(stuck), .bump(bump), .senseOpen(senseOpen),
      .senseClosed(senseClosed));
   // Bits of v are command, system loop, shutter loop, stuck vane
   task automatic go(input logic [3:0] v, input logic [3:0] t, input int n);
      @(posedge clk);
      {shutterCmd, sysLoopClosed, shutterLoopClosed, stuck} <= v;
      temp <= t;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rst(input logic [3:0] v);
      @(posedge clk);
      rstn <= 1'h0;
      {shutterCmd, sysLoopClosed, shutterLoopClosed, stuck} <= v;
      temp <= 4'h0;
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
   endtask
   task automatic t_move;
      rst(4'h6);
      go(4'h6, 4'h0, 12);
      `CHK("closedStatP", 1'h1, closedStatP)
      `CHK("runPermit", 1'h1, runPermit)
      `CHK("driveClose", 1'h1, driveClose)
      go(4'hE, 4'h0, 20);
      `CHK("openStatP", 1'h1, openStatP)
      `CHK("openStatN", 1'h0, openStatN)
      go(4'h6, 4'h0, 20);
      `CHK("closedStatP", 1'h1, closedStatP)
      `CHK("shutterFaultP", 1'h0, shutterFaultP)
   endtask
   task automatic t_loops;
      rst(4'h4);
      go(4'h4, 4'h0, 10);
      `CHK("closedStatP", 1'h0, closedStatP)
      `CHK("runPermit", 1'h1, runPermit)
      `CHK("driveClose", 1'h0, driveClose)
      go(4'hC, 4'h0, 10);
      `CHK("driveOpen", 1'h0, driveOpen)
      go(4'hA, 4'h0, 6);
      `CHK("runPermit", 1'h0, runPermit)
      `CHK("modEnable", 1'h0, modEnable)
      `CHK("simmerEnable", 1'h0, simmerEnable)
   endtask
   task automatic t_faults;
      rst(4'h6);
      go(4'hF, 4'h0, 35);
      `CHK("shutterFaultP", 1'h1, shutterFaultP)
      `CHK("runPermit", 1'h0, runPermit)
      `CHK("closedStatP", 1'h0, closedStatP)
      go(4'hE, 4'h0, 30);
      `CHK("shutterFaultP", 1'h1, shutterFaultP)
      rst(4'h6);
      go(4'hE, 4'h0, 20);
      go(4'h7, 4'h0, 55);
      `CHK("shutterFaultP", 1'h1, shutterFaultP)
      `CHK("openStatP", 1'h0, openStatP)
      // Vane knocked off closed with no transit running, so only the close check can fire
      rst(4'h6);
      go(4'h7, 4'h0, 10);
      bump <= 1'h1;
      go(4'h7, 4'h0, 50);
      bump <= 1'h0;
      `CHK("driveOpen", 1'h0, driveOpen)
      `CHK("closedStatP", 1'h0, closedStatP)
      `CHK("shutterFaultP", 1'h1, shutterFaultP)
   endtask
   // Each reporting controller on its own, so a dropped bit shows
   task automatic t_temp;
      for (int i = 0; i < 4; i++)
      begin
         rst(4'h6);
         go(4'hE, 4'h0, 20);
         go(4'hE, 4'h1 << i, 6);
         `CHK("overTempP", 1'h1, overTempP)
         `CHK("runPermit", 1'h0, runPermit)
         `CHK("openStatP", 1'h0, openStatP)
         go(4'hE, 4'h0, 6);
         `CHK("overTempP", 1'h1, overTempP)
      end
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      rstn = 1'h0;
      {shutterCmd, sysLoopClosed, shutterLoopClosed, stuck} = 4'h6;
      temp = 4'h0;
      bump = 1'h0;
      t_move();
      t_loops();
      t_faults();
      t_temp();
      close_out();
   end
endmodule
`default_nettype wire

// [tb/shutter_mech_model.sv]
// Behavioural shutter mechanism with end-position sensors
`timescale 1ns/1ps
`default_nettype none
module shutter_mech_model #(
   parameter int TRAVEL = 8
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic driveOpen,
   input  wire logic driveClose,
   input  wire logic stuck,
   input  wire logic bump,
   output var  logic senseOpen,
   output var  logic senseClosed
);
   int pos;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         pos <= 0;
      // A knock parks the vane mid-travel with no drive behind it
      else if (bump)
         pos <= TRAVEL / 2;
      else if (!stuck && driveOpen && pos < TRAVEL)
         pos <= pos + 1;
      else if (!stuck && driveClose && pos > 0)
         pos <= pos - 1;
   // Mid-travel shows neither sensor, as a real vane would
   assign senseOpen   = (pos == TRAVEL);
   assign senseClosed = (pos == 0);
endmodule
`default_nettype wire
